// ### hdl/occ_osc_ctrl.sv
// oscillator control register with write lock and primary clock failure recovery
// Functional notes
// - unlock needs E7 then 18 writes
// - next write updates register unless a same-cycle failure switchover wins, then relocks
// - other write sequences leave register unchanged
// - unlock values must be consecutive writes; a repeated E7 is tolerated
// - other register accesses never disturb lock
// - re-enabled detection resumes monitoring
// - precision oscillator enabled after reset
// - source change keeps precision oscillator on
// - failure raises non-maskable clock fail event
// - failure switches source to watchdog oscillator
// - no switch if watchdog selected or off
// - recovery independent of watchdog reset function
// - failure when primary below about 1 kHz
// - cpu continues on watchdog clock, takes vector
`timescale 1ns/1ps
module occ_osc_ctrl
  import occ_pkg::*;
#(
  parameter int fail_cycles = occ_fail_cycles
)
(
  input wire logic clk, // system clock, 250 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic ctrl_wr, // one-cycle write strobe to the control register
  input wire logic [7:0] ctrl_wdata, // write data
  input wire logic primary_tick, // one pulse per primary oscillator edge, synchronous
  input wire logic wdo_running, // watchdog oscillator is running
  output logic [7:0] oscillator_control_register, // current register contents
  output logic internal_precision_oscillator, // precision oscillator enable
  output logic [2:0] clock_source_select, // selected system clock source
  output logic primary_fail_detect_enable, // primary failure detection enable
  output logic watchdog_osc_fail_detect_enable, // watchdog failure detection enable
  output logic unlocked, // lock open as of the previous cycle, registered one cycle behind lock_reg
  output logic clk_fail_event, // one-cycle non-maskable clock fail event
  output logic clk_fail_flag // level: primary failure detected, whether or not a switchover occurred
);
  occ_lock_e lock_reg;
  logic [7:0] ctrl_reg;
  logic [occ_cnt_w-1:0] idle_cnt_reg;
  logic fail_flag_reg;
  logic event_reg;
  logic fail_now;
  logic can_recover;

  // only control-register writes advance the lock; other traffic never reaches it
  always_ff @(posedge clk)
  begin
    if (rst)
      lock_reg <= occ_locked;
    else if (ctrl_wr)
    begin
      case (lock_reg)
        occ_locked:
          if (ctrl_wdata == occ_unlock_first)
            lock_reg <= occ_half;
        occ_half:
          // a repeated E7 keeps the half state rather than restart the count
          if (ctrl_wdata == occ_unlock_second)
            lock_reg <= occ_open;
          else if (ctrl_wdata != occ_unlock_first)
            lock_reg <= occ_locked;
        occ_open:
          lock_reg <= occ_locked;
        default:
          lock_reg <= occ_locked;
      endcase
    end
  end

  assign fail_now = (idle_cnt_reg >= occ_cnt_w'(fail_cycles - 1));
  assign can_recover = wdo_running && ctrl_reg[occ_wdo_en_bit]
    && (ctrl_reg[occ_sel_lsb +: occ_sel_w] != occ_sel_wdo);

  // counts system clocks without a primary edge; 1 ms is the midpoint of the 0.5..1.5 ms band
  always_ff @(posedge clk)
  begin
    if (rst || primary_tick || !ctrl_reg[occ_pfail_en_bit])
      idle_cnt_reg <= '0;
    else if (!fail_now)
      idle_cnt_reg <= idle_cnt_reg + occ_cnt_w'(1);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_reg <= occ_ctrl_reset;
    else if (fail_now && can_recover && !fail_flag_reg)
      ctrl_reg[occ_sel_lsb +: occ_sel_w] <= occ_sel_wdo;
    else if (ctrl_wr && lock_reg == occ_open)
      ctrl_reg <= ctrl_wdata;
  end

  // one pulse per failure episode; the flag masks repeats until detection is re-armed
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      event_reg <= 1'b0;
    end
    else
    begin
      event_reg <= fail_now && !fail_flag_reg;
    end
  end

  // flag holds until detection is turned off; set beats clear in one cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fail_flag_reg <= 1'b0;
    end
    else if (fail_now)
    begin
      fail_flag_reg <= 1'b1;
    end
    else if (!ctrl_reg[occ_pfail_en_bit])
    begin
      fail_flag_reg <= 1'b0;
    end
  end

  // every output is registered one cycle behind internal state; all but unlocked, a decode of lock_reg, are plain copies
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      oscillator_control_register <= occ_ctrl_reset;
    end
    else
    begin
      oscillator_control_register <= ctrl_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      unlocked <= 1'b0;
    end
    else
    begin
      unlocked <= (lock_reg == occ_open);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clk_fail_event <= 1'b0;
    end
    else
    begin
      clk_fail_event <= event_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clk_fail_flag <= 1'b0;
    end
    else
    begin
      clk_fail_flag <= fail_flag_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      internal_precision_oscillator <= occ_ctrl_reset[occ_ipo_en_bit];
    end
    else
    begin
      // never cleared by a source change, only by a software write
      internal_precision_oscillator <= ctrl_reg[occ_ipo_en_bit];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clock_source_select <= occ_ctrl_reset[occ_sel_lsb +: occ_sel_w];
    end
    else
    begin
      clock_source_select <= ctrl_reg[occ_sel_lsb +: occ_sel_w];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      primary_fail_detect_enable <= occ_ctrl_reset[occ_pfail_en_bit];
    end
    else
    begin
      primary_fail_detect_enable <= ctrl_reg[occ_pfail_en_bit];
    end
  end

  // stored and shown only; no watchdog oscillator detector lives in this block
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      watchdog_osc_fail_detect_enable <= occ_ctrl_reset[occ_wfail_en_bit];
    end
    else
    begin
      watchdog_osc_fail_detect_enable <= ctrl_reg[occ_wfail_en_bit];
    end
  end
endmodule : occ_osc_ctrl

// ### inc/occ_pkg.sv
// package for the oscillator control lock and failure recovery block
package occ_pkg;
  localparam logic [7:0] occ_unlock_first = 8'he7;
  localparam logic [7:0] occ_unlock_second = 8'h18;
  // control register layout
  localparam int occ_ipo_en_bit = 7;
  localparam int occ_wdo_en_bit = 6;
  localparam int occ_pfail_en_bit = 5;
  localparam int occ_wfail_en_bit = 4;
  localparam int occ_sel_lsb = 0;
  localparam int occ_sel_w = 3;
  localparam logic [7:0] occ_ctrl_reset = 8'he0;
  localparam logic [2:0] occ_sel_ipo = 3'h0;
  localparam logic [2:0] occ_sel_wdo = 3'h3;
  // failure threshold: 1 kHz nominal, so no primary edge for 1 ms
  localparam int occ_clk_mhz = 250;
  localparam int occ_fail_time_us = 1000;
  localparam int occ_fail_cycles = occ_fail_time_us * occ_clk_mhz;
  localparam int occ_cnt_w = 20;
  typedef enum logic [2:0] {
    occ_locked = 3'b001,
    occ_half = 3'b010,
    occ_open = 3'b100
  } occ_lock_e;
endpackage : occ_pkg

// ### sim/occ_chk_properties.sv
// assertions for the oscillator control block
`timescale 1ns/1ps
module occ_chk
  import occ_pkg::*;
(
  input wire logic clk, rst, ctrl_wr, primary_tick, wdo_running, unlocked, clk_fail_event,
  input wire logic [7:0] ctrl_wdata, // write data
  input wire logic [7:0] oscillator_control_register // register contents
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  reg_locked_a: assert property (
    !$stable(oscillator_control_register) |-> $past(ctrl_wr && unlocked, 2) || clk_fail_event)
    else $error("locked change");
  relock_a: assert property (ctrl_wr && unlocked |-> ##2 !unlocked)
    else $error("no relock");
  unlock_order_a: assert property (
    $rose(unlocked) |-> $past(ctrl_wr, 2) && $past(ctrl_wdata, 2) == occ_unlock_second)
    else $error("bad unlock");
  ipo_kept_a: assert property ($fell(oscillator_control_register[occ_ipo_en_bit]) |->
    $past(ctrl_wr && unlocked && !ctrl_wdata[occ_ipo_en_bit], 2)) else $error("ipo off");
  fail_switch_a: assert property (clk_fail_event &&
    $past(wdo_running && oscillator_control_register[occ_wdo_en_bit], 2) |->
    oscillator_control_register[2:0] == occ_sel_wdo) else $error("no switch");
  no_switch_a: assert property (
    clk_fail_event && !$past(wdo_running, 2) |-> $stable(oscillator_control_register))
    else $error("bad switch");
  event_pulse_a: assert property (clk_fail_event |=> !clk_fail_event)
    else $error("long event");
  fail_quiet_a: assert property (clk_fail_event |-> !$past(primary_tick, 4))
    else $error("early fail");
endmodule : occ_chk

// ### sim/test_occ_osc_ctrl.sv
// self-checking bench for the oscillator control block
`timescale 1ns/1ps
module test_occ_osc_ctrl;
  import occ_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ctrl_wr = 1'b0, primary_tick = 1'b0, wdo_running = 1'b1;
  logic tick_on = 1'b1, internal_precision_oscillator, primary_fail_detect_enable, unlocked;
  logic watchdog_osc_fail_detect_enable, clk_fail_event, clk_fail_flag;
  logic [7:0] ctrl_wdata = 8'h00, oscillator_control_register;
  logic [2:0] clock_source_select;
  int err_count = 0, checks_done = 0, seed = 63, st = 0, cyc = 0, m = 8'he0, k;
  occ_osc_ctrl #(.fail_cycles(20)) DUT (.*);
  initial forever #2 clk = ~clk;
  always @(posedge clk)
  begin
    primary_tick <= tick_on && !primary_tick;
    cyc++;
    if (cyc > 5000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= d;
    @(posedge clk);
    ctrl_wr <= 1'b0;
    if (st == 2)
      m = d;
    st = st == 2 ? 0 : d == occ_unlock_first ? 1 : st == 1 && d == occ_unlock_second ? 2 : 0;
    repeat (2) @(posedge clk);
    // look just after the edge, once the design's updates have settled
    #1;
    chk(oscillator_control_register, m[7:0]);
    chk(unlocked, st == 2);
    chk({internal_precision_oscillator, primary_fail_detect_enable,
      watchdog_osc_fail_detect_enable, clock_source_select},
      {m[7], m[5], m[4], m[2:0]});
  endtask : wr
  task automatic fail_case(input logic [7:0] d, input logic run, input logic [2:0] sel);
    int n;
    // a plain write first drops any lock progress left by earlier traffic
    wr(8'h00);
    wr(occ_unlock_first);
    wr(occ_unlock_second);
    wr(d & 8'hdf);
    wr(occ_unlock_first);
    wr(occ_unlock_second);
    wr(d);
    @(posedge clk);
    wdo_running <= run;
    tick_on <= 1'b0;
    n = 0;
    while (clk_fail_event !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    tick_on <= 1'b1;
    chk(n > 15 && n < 29, 1'b1);
    chk(clock_source_select, sel);
    chk(clk_fail_flag, 1'b1);
    m[2:0] = sel;
  endtask : fail_case
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    st = 0;
    m = 8'he0;
    #1;
    chk(oscillator_control_register, occ_ctrl_reset);
    chk(unlocked, 1'b0);
  endtask : do_reset
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    do_reset();
    repeat (40)
    begin
      k = $random(seed) & 3;
      wr(k == 0 ? occ_unlock_first : k == 1 ? occ_unlock_second : 8'($random(seed)));
      repeat ($random(seed) & 3) @(posedge clk);
    end
    fail_case(8'he0, 1'b1, occ_sel_wdo);
    fail_case(8'he3, 1'b1, occ_sel_wdo);
    fail_case(8'he0, 1'b0, occ_sel_ipo);
    wr(occ_unlock_first);
    wr(occ_unlock_second);
    wr(8'hc0);
    tick_on <= 1'b0;
    repeat (40)
    begin
      @(posedge clk);
      #1;
      chk(clk_fail_event, 1'b0);
    end
    chk(clk_fail_flag, 1'b0);
    tick_on <= 1'b1;
    wr(occ_unlock_first);
    wr(occ_unlock_second);
    do_reset();
    wr(8'h55);
    report_and_stop();
  end
endmodule : test_occ_osc_ctrl
bind occ_osc_ctrl occ_chk u_chk (.*);
